// [tau_top.sv]
// table access unit: table latch, pointer, reset control and external memory control
// assumes the core issues one-cycle operation strobes and waits for OP_DONE
`default_nettype none
`include "tau_params.svh"

// How it works
// - program memory 16 bits, data 8 bits; bytes move only via latch.
// - transfers are per byte; any byte address is legal.
// - long write enable plus programming voltage allows internal long writes.
// - long write enable cleared only by power-on or master-clear reset.
// - long write enable ignored for external-memory writes.
// - bit 7 enables interrupt priority levels.
// - reset-instruction flag 0 after reset instruction; bit 5 reads 0.
// - timeout and powerdown flags follow power-up, watchdog and sleep events.
// - power-on clears power flag; brown-out or power-on clears brown-out flag.
// - external memory control exists only with an external bus.
// - bus-disable bit hands bus pins to general I/O.
// - ram-mapping bit moves ram to program space; data reads return 00h.
// - wait field 11/10/01/00 gives 0/1/2/3 instruction-cycle waits.
// - word mode outputs both latch bytes, high strobe on second byte.
// - byte-select and byte modes copy latch to both halves with strobes.
// - the latch is an 8-bit register holding each moved byte.
// - 22-bit pointer from three bytes; top bit selects configuration area.
// - automatic updates change only the low 21 bits.
// - each form leaves, post-increments, post-decrements or pre-increments pointer.
// - table read loads latch from program byte over two instruction cycles.
// - internal even-address write loads holding latch; odd starts long write if enabled, else loads holding latch.
module tau_top
    import tau_pkg::*;
#(
    parameter bit HAS_EXT_BUS = 1'b1,
    parameter int TCY_CLKS = `TAU_TCY_CLKS
)
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // reset causes and status events as one-cycle pulses from core logic, then programming-voltage pin and unlock levels
    input wire logic POR_EVT,
    input wire logic MASTER_CLEAR_PIN_EVT,
    input wire logic BOR_EVT,
    input wire logic RESET_INSTR_EVT,
    input wire logic WDT_CLEAR_EVT,
    input wire logic SLEEP_EVT,
    input wire logic WDT_TIMEOUT_EVT,
    input wire logic VPP_PRESENT,
    input wire logic CFG_UNLOCKED,
    // special-function register port
    input wire logic SFR_WR,
    input wire logic [2:0] SFR_SEL,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // table operation request
    input wire logic OP_RD,
    input wire logic OP_WR,
    input wire tau_upd_t OP_UPD,
    input wire logic OP_EXTERNAL,
    output logic OP_DONE,
    // program memory side
    output logic [21:0] PM_ADDR,
    output logic PM_RD,
    input wire logic [7:0] PM_RDATA,
    output logic PM_HOLD_WR,
    output logic PM_LONG_WR,
    output logic [15:0] PM_WDATA,
    output tau_bus_t EXT_BUS,
    // status outputs
    output logic IRQ_PRIO_EN,
    output logic BUS_PINS_DIS,
    output logic RAM_IN_PROG
);
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_WAIT, ST_DONE} st_t;
    typedef struct packed {
        st_t st;
        logic [7:0] reset_control_status;
        logic [7:0] memc;
        logic [7:0] latch;
        logic [7:0] latch_lo;
        logic [21:0] ptr;
        logic [21:0] acc;
        logic [21:0] nxt;
        logic is_wr;
        logic is_ext;
        logic [4:0] tcnt;
        logic [1:0] wcnt;
        logic [7:0] rdata;
        logic done;
        logic pm_rd;
        logic hold_wr;
        logic long_wr;
        logic [15:0] wdata;
        tau_bus_t bus;
        logic vpp_meta;
        logic vpp_sync;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [21:0] step_acc;
    logic [21:0] step_nxt;

    // wait states from the 2-bit field: 11->0 ... 00->3
    function automatic logic [1:0] wait_of(input logic [1:0] f);
        wait_of = 2'h3 - f;
    endfunction

    // register read decode
    function automatic logic [7:0] reg_read(input state_t s, input logic [2:0] sel);
        case (sel)
            `TAU_SEL_RESET_CONTROL_STATUS: reg_read = s.reset_control_status & `TAU_RC_WMASK;
            `TAU_SEL_MEMC: reg_read = HAS_EXT_BUS ? (s.memc & `TAU_MC_WMASK) : 8'h00;
            `TAU_SEL_LATCH: reg_read = s.latch;
            `TAU_SEL_PTRU: reg_read = {2'h0, s.ptr[21:16]};
            `TAU_SEL_PTRH: reg_read = s.ptr[15:8];
            `TAU_SEL_PTRL: reg_read = s.ptr[7:0];
            default: reg_read = 8'h00;
        endcase
    endfunction

    tau_ptr_step u_step (
        .ptr(s_q.ptr),
        .upd(OP_UPD),
        .acc_addr(step_acc),
        .next_ptr(step_nxt)
    );

    // -----------------------------------------
    // next-state logic
    // -----------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.pm_rd = 1'b0;
        s_d.hold_wr = 1'b0;
        s_d.long_wr = 1'b0;
        s_d.bus.wr_high = 1'b0;
        s_d.bus.wr_low = 1'b0;
        s_d.bus.upper_sel = 1'b0;
        s_d.bus.lower_sel = 1'b0;
        // programming voltage comes from a pin: two flops before use
        s_d.vpp_meta = VPP_PRESENT;
        s_d.vpp_sync = s_q.vpp_meta;
        // register writes; reset control and memory control registers blocked whole while locked, pointer always writable, latch unless a table read completes
        if (SFR_WR)
        begin
            case (SFR_SEL)
                `TAU_SEL_RESET_CONTROL_STATUS:
                    if (CFG_UNLOCKED)
                    begin
                        s_d.reset_control_status[`TAU_RC_IRQ_PRIORITY_ENABLE] = SFR_WDATA[`TAU_RC_IRQ_PRIORITY_ENABLE];
                        // sticky: software may set but never clear
                        s_d.reset_control_status[`TAU_RC_LWE] = s_q.reset_control_status[`TAU_RC_LWE] |
                            SFR_WDATA[`TAU_RC_LWE];
                        s_d.reset_control_status[`TAU_RC_POR] = SFR_WDATA[`TAU_RC_POR];
                        s_d.reset_control_status[`TAU_RC_BOR] = SFR_WDATA[`TAU_RC_BOR];
                    end
                `TAU_SEL_MEMC:
                    if (HAS_EXT_BUS && CFG_UNLOCKED)
                        s_d.memc = SFR_WDATA & `TAU_MC_WMASK;
                `TAU_SEL_LATCH: s_d.latch = SFR_WDATA;
                `TAU_SEL_PTRU: s_d.ptr[21:16] = SFR_WDATA[5:0];
                `TAU_SEL_PTRH: s_d.ptr[15:8] = SFR_WDATA;
                `TAU_SEL_PTRL: s_d.ptr[7:0] = SFR_WDATA;
                default: s_d.reset_control_status = s_q.reset_control_status;
            endcase
        end
        // status events; hardware events win over software writes
        if (RESET_INSTR_EVT)
            s_d.reset_control_status[`TAU_RC_RI] = 1'b0;
        if (WDT_CLEAR_EVT)
        begin
            s_d.reset_control_status[`TAU_RC_TO] = 1'b1;
            s_d.reset_control_status[`TAU_RC_PD] = 1'b1;
        end
        if (SLEEP_EVT)
        begin
            s_d.reset_control_status[`TAU_RC_TO] = 1'b1;
            s_d.reset_control_status[`TAU_RC_PD] = 1'b0;
        end
        if (WDT_TIMEOUT_EVT)
            s_d.reset_control_status[`TAU_RC_TO] = 1'b0;
        if (BOR_EVT)
            s_d.reset_control_status[`TAU_RC_BOR] = 1'b0;
        if (MASTER_CLEAR_PIN_EVT)
            s_d.reset_control_status[`TAU_RC_LWE] = 1'b0;
        if (POR_EVT)
            s_d.reset_control_status = `TAU_RC_RESET;
        s_d.reset_control_status[5] = 1'b0;
        // table operation sequencer
        case (s_q.st)
            ST_IDLE:
                if (OP_RD || OP_WR)
                begin
                    s_d.acc = step_acc;
                    s_d.nxt = step_nxt;
                    s_d.is_wr = OP_WR;
                    s_d.is_ext = OP_EXTERNAL;
                    s_d.tcnt = 5'h00;
                    s_d.wcnt = OP_EXTERNAL ? wait_of(s_q.memc[5:4]) : 2'h0;
                    s_d.st = ST_ACCESS;
                end
            ST_ACCESS:
            begin
                s_d.tcnt = s_q.tcnt + 5'h01;
                if (s_q.tcnt == 5'h00)
                begin
                    if (!s_q.is_wr)
                        s_d.pm_rd = 1'b1;
                    else if (!s_q.is_ext)
                    begin
                        // even byte loads holding latch, odd programs the word when enable bit and voltage are present
                        if (!s_q.acc[0])
                            s_d.hold_wr = 1'b1;
                        else if (s_q.reset_control_status[`TAU_RC_LWE] && s_q.vpp_sync)
                            s_d.long_wr = 1'b1;
                        else
                            s_d.hold_wr = 1'b1;
                        s_d.wdata = {s_q.latch, s_q.latch_lo};
                        s_d.latch_lo = s_q.acc[0] ? s_q.latch_lo : s_q.latch;
                    end
                    else
                    begin
                        // external write, enable bit plays no part
                        case (s_q.memc[1:0])
                            `TAU_WM_WORD:
                            begin
                                s_d.latch_lo = s_q.acc[0] ? s_q.latch_lo : s_q.latch;
                                s_d.bus.data = {s_q.latch, s_q.latch_lo};
                                s_d.bus.wr_high = s_q.acc[0];
                            end
                            `TAU_WM_BSEL:
                            begin
                                s_d.bus.data = {s_q.latch, s_q.latch};
                                s_d.bus.wr_high = 1'b1;
                                s_d.bus.upper_sel = s_q.acc[0];
                                s_d.bus.lower_sel = !s_q.acc[0];
                            end
                            `TAU_WM_BYTE:
                            begin
                                s_d.bus.data = {s_q.latch, s_q.latch};
                                s_d.bus.wr_high = s_q.acc[0];
                                s_d.bus.wr_low = !s_q.acc[0];
                            end
                            default: s_d.bus = s_q.bus; // reserved mode: no strobe
                        endcase
                    end
                end
                if (s_q.tcnt == 5'(2 * TCY_CLKS - 2))
                    s_d.st = (s_q.wcnt == 2'h0) ? ST_DONE : ST_WAIT;
            end
            ST_WAIT:
            begin
                s_d.tcnt = s_q.tcnt + 5'h01;
                if (s_q.tcnt == 5'(2 * TCY_CLKS - 1 + TCY_CLKS * 32'(s_q.wcnt) - 1))
                    s_d.st = ST_DONE;
            end
            ST_DONE:
            begin
                // read data lands in the latch, RAM-mapped reads return zero
                if (!s_q.is_wr)
                    s_d.latch = (s_q.is_ext && s_q.memc[`TAU_MC_PGRAM]) ? 8'h00 : PM_RDATA;
                if (SFR_WR && SFR_SEL >= `TAU_SEL_PTRU)
                    s_d.ptr = s_d.ptr;
                else
                    s_d.ptr = s_q.nxt;
                s_d.done = 1'b1;
                s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
        s_d.rdata = reg_read(s_d, SFR_SEL);
    end

    // -----------------------------------------
    // state register
    // -----------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s_q <= '0;
            s_q.reset_control_status <= `TAU_RC_RESET;
            s_q.memc <= `TAU_MC_RESET;
        end
        else
            s_q <= s_d;
    end

    // outputs, all flopped
    assign SFR_RDATA = s_q.rdata;
    assign OP_DONE = s_q.done;
    assign PM_ADDR = s_q.acc;
    assign PM_RD = s_q.pm_rd;
    assign PM_HOLD_WR = s_q.hold_wr;
    assign PM_LONG_WR = s_q.long_wr;
    assign PM_WDATA = s_q.wdata;
    assign EXT_BUS = s_q.bus;
    assign IRQ_PRIO_EN = s_q.reset_control_status[`TAU_RC_IRQ_PRIORITY_ENABLE];
    assign BUS_PINS_DIS = s_q.memc[`TAU_MC_BUSDIS];
    assign RAM_IN_PROG = s_q.memc[`TAU_MC_PGRAM];

    // -----------------------------------------
    // checks
    // -----------------------------------------
    AST_LWE_STICKY: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $fell(s_q.reset_control_status[6]) |-> $past(POR_EVT) || $past(MASTER_CLEAR_PIN_EVT))
        else $error("long write enable cleared without reset");
    AST_BIT5_ZERO: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        SFR_RDATA[5] == 1'b0 || $past(SFR_SEL) != `TAU_SEL_RESET_CONTROL_STATUS)
        else $error("reserved bit read nonzero");
    AST_RI_CLR: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        RESET_INSTR_EVT && !POR_EVT |=> !s_q.reset_control_status[4])
        else $error("reset instruction flag not cleared");
    AST_TO_CLR: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        WDT_TIMEOUT_EVT && !POR_EVT |=> !s_q.reset_control_status[3])
        else $error("timeout flag not cleared");
    AST_PD_CLR: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        SLEEP_EVT && !WDT_CLEAR_EVT && !POR_EVT |=> !s_q.reset_control_status[2])
        else $error("powerdown flag not cleared on sleep");
    AST_BOR_CLR: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        BOR_EVT || POR_EVT |=> !s_q.reset_control_status[0])
        else $error("brownout flag not cleared");
    AST_TOP_BIT: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        s_q.st == ST_DONE && !SFR_WR |=> s_q.ptr[21] == $past(s_q.ptr[21]))
        else $error("pointer top bit altered");
    AST_LONG_GATE: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        PM_LONG_WR |-> $past(s_q.reset_control_status[6]) && $past(s_q.vpp_sync) && PM_ADDR[0])
        else $error("long write without enable");
    AST_RD_TIME: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        s_q.st == ST_IDLE && OP_RD && !OP_EXTERNAL |=> ##[1:8] OP_DONE)
        else $error("table read overran two instruction cycles");
    AST_WORD_STROBE: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        EXT_BUS.wr_high && $past(s_q.memc[1:0]) == 2'h3 |-> PM_ADDR[0])
        else $error("word mode strobe on first byte");
endmodule
`default_nettype wire

// [tau_params.svh]
// constants for the table access unit: register layout, field positions, reset values
// assumes a 50 MHz core clock and an instruction cycle of four core clocks
`ifndef TAU_PARAMS_SVH
`define TAU_PARAMS_SVH

// ---------------------------------------------
// register select codes on the special-function port
// ---------------------------------------------
`define TAU_SEL_RESET_CONTROL_STATUS 3'h0
`define TAU_SEL_MEMC 3'h1
`define TAU_SEL_LATCH 3'h2
`define TAU_SEL_PTRU 3'h3
`define TAU_SEL_PTRH 3'h4
`define TAU_SEL_PTRL 3'h5

// ---------------------------------------------
// reset control field positions
// ---------------------------------------------
`define TAU_RC_IRQ_PRIORITY_ENABLE 7
`define TAU_RC_LWE 6
`define TAU_RC_RI 4
`define TAU_RC_TO 3
`define TAU_RC_PD 2
`define TAU_RC_POR 1
`define TAU_RC_BOR 0
`define TAU_RC_WMASK 8'hDF
`define TAU_RC_RESET 8'h1C

// ---------------------------------------------
// external memory control field positions
// ---------------------------------------------
`define TAU_MC_BUSDIS 7
`define TAU_MC_PGRAM 6
`define TAU_MC_WAIT_HI 5
`define TAU_MC_WAIT_LO 4
`define TAU_MC_WMASK 8'hF3
`define TAU_MC_RESET 8'h00

// ---------------------------------------------
// write modes and timing
// ---------------------------------------------
`define TAU_WM_WORD 2'h3
`define TAU_WM_RSVD 2'h2
`define TAU_WM_BSEL 2'h1
`define TAU_WM_BYTE 2'h0
`define TAU_TCY_CLKS 4
`define TAU_LOW_MASK 21'h1FFFFF

`endif

// [tau_pkg.sv]
// types for the table access unit
// assumes tau_params.svh for all numeric constants
`default_nettype none
package tau_pkg;
    typedef enum logic [1:0] {TAU_UPD_NONE, TAU_UPD_POSTINC, TAU_UPD_POSTDEC,
        TAU_UPD_PREINC} tau_upd_t;
    typedef struct packed {
        logic [15:0] data;
        logic wr_high;
        logic wr_low;
        logic upper_sel;
        logic lower_sel;
    } tau_bus_t;
endpackage
`default_nettype wire

// [tau_ptr_step.sv]
// table pointer update step: next address and the address used for the access
// assumes a 22-bit pointer whose top bit is never touched by stepping
`default_nettype none
`include "tau_params.svh"
module tau_ptr_step
    import tau_pkg::*;
(
    // pointer in
    input wire logic [21:0] ptr,
    input wire tau_upd_t upd,
    // results
    output logic [21:0] acc_addr,
    output logic [21:0] next_ptr
);
    logic [20:0] inc_low;
    logic [20:0] dec_low;

    // low field wraps, top bit kept
    assign inc_low = ptr[20:0] + 21'h000001;
    assign dec_low = ptr[20:0] - 21'h000001;

    // select access address and post-access pointer
    always_comb
    begin
        acc_addr = ptr;
        next_ptr = ptr;
        case (upd)
            TAU_UPD_POSTINC: next_ptr = {ptr[21], inc_low};
            TAU_UPD_POSTDEC: next_ptr = {ptr[21], dec_low};
            TAU_UPD_PREINC:
            begin
                acc_addr = {ptr[21], inc_low};
                next_ptr = {ptr[21], inc_low};
            end
            default: next_ptr = ptr;
        endcase
    end
endmodule
`default_nettype wire

// [tau_pm_model.sv]
// program memory model: answers table reads with a byte derived from the address
// assumes the unit's registered read strobe, access address and done pulse
`default_nettype none
module tau_pm_model
    import tau_pkg::*;
#(
    parameter int LAT = 3
)
(
    // clock
    input wire logic clk,
    // unit side
    input wire logic [21:0] addr,
    input wire logic rd,
    input wire logic done,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [21:0] a_q = 22'h000000;
    logic [3:0] cnt_q = 4'h0;
    logic vld_q = 1'b0;
    logic [7:0] b;
    // each 16-bit word holds two bytes, each a mix of its own byte address
    assign b = a_q[7:0] ^ a_q[15:8] ^ {2'h0, a_q[21:16]} ^ 8'hA5;
    // data shows only after the latency and until done, inverted otherwise
    assign rdata = (vld_q && cnt_q == 4'h0) ? b : ~b;
    // latch the address on a read strobe, then count down the latency
    always @(posedge clk)
    begin
        if (rd)
        begin
            a_q <= addr;
            cnt_q <= LAT[3:0];
            vld_q <= 1'b1;
        end
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        if (done)
            vld_q <= 1'b0;
    end
endmodule
`default_nettype wire

// [tb_table_access_unit.sv]
// self-checking bench for the table access unit
// assumes tau_pm_model on the program memory side and default four-clock cycles
`default_nettype none
module tb_table_access_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import tau_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] evs = 7'h00;
    logic vpp = 1'b0;
    logic unl = 1'b1;
    logic sfr_wr = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdat;
    logic op_rd = 1'b0;
    logic op_wr = 1'b0;
    tau_upd_t upd = TAU_UPD_NONE;
    logic ext = 1'b0;
    logic done, pm_rd, hold, lng, ipe, bpd, rip;
    logic [21:0] pm_addr;
    logic [7:0] pm_rdata;
    logic [15:0] wdata;
    tau_bus_t bus;
    int err_count = 0;
    int num_checks = 0;
    tau_top dut (
        .CORE_CLK(clk), .ARST_N(rst_n), .POR_EVT(evs[0]), .MASTER_CLEAR_PIN_EVT(evs[1]),
        .BOR_EVT(evs[2]), .RESET_INSTR_EVT(evs[3]), .WDT_CLEAR_EVT(evs[4]),
        .SLEEP_EVT(evs[5]), .WDT_TIMEOUT_EVT(evs[6]), .VPP_PRESENT(vpp),
        .CFG_UNLOCKED(unl), .SFR_WR(sfr_wr), .SFR_SEL(sel), .SFR_WDATA(wd),
        .SFR_RDATA(rdat), .OP_RD(op_rd), .OP_WR(op_wr), .OP_UPD(upd),
        .OP_EXTERNAL(ext), .OP_DONE(done), .PM_ADDR(pm_addr), .PM_RD(pm_rd),
        .PM_RDATA(pm_rdata), .PM_HOLD_WR(hold), .PM_LONG_WR(lng), .PM_WDATA(wdata),
        .EXT_BUS(bus), .IRQ_PRIO_EN(ipe), .BUS_PINS_DIS(bpd), .RAM_IN_PROG(rip)
    );
    tau_pm_model pm (.clk(clk), .addr(pm_addr), .rd(pm_rd), .done(done), .rdata(pm_rdata));
    // clock source
    initial
    begin
        forever #10 clk = ~clk;
    end
    // --------------------------------
    // shared tasks
    // --------------------------------
    function automatic logic [7:0] pmb(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]} ^ 8'hA5;
    endfunction
    task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stp();
        @(posedge clk);
        #1;
    endtask
    task automatic swr(input logic [2:0] s, input logic [7:0] d);
        sel = s;
        wd = d;
        sfr_wr = 1'b1;
        stp();
        sfr_wr = 1'b0;
        // let an edge pass so back-to-back writes never re-raise the strobe at once
        stp();
    endtask
    task automatic rd(input logic [2:0] s, output logic [7:0] v);
        sel = s;
        stp();
        stp();
        v = rdat;
    endtask
    task automatic ev(input int k);
        evs[k] = 1'b1;
        stp();
        evs[k] = 1'b0;
    endtask
    task automatic setp(input logic [21:0] p);
        swr(3'h3, {2'h0, p[21:16]});
        swr(3'h4, p[15:8]);
        swr(3'h5, p[7:0]);
    endtask
    // one table operation; n counts edges to done, f gathers the write strobes
    task automatic op(input logic w, input tau_upd_t u, input logic x,
        output int n, output logic [5:0] f);
        op_wr = w;
        op_rd = !w;
        upd = u;
        ext = x;
        stp();
        op_wr = 1'b0;
        op_rd = 1'b0;
        n = 0;
        f = 6'h00;
        while (done !== 1'b1 && n < 60)
        begin
            f |= {hold, lng, bus.wr_high, bus.wr_low, bus.upper_sel, bus.lower_sel};
            stp();
            n++;
        end
        chk("op done", 22'(1), 22'(done));
        f |= {hold, lng, bus.wr_high, bus.wr_low, bus.upper_sel, bus.lower_sel};
        stp();
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_regs();
        logic [7:0] v;
        rd(3'h0, v); chk("reset_control_status reset", 8'h1C, v);
        unl = 1'b0;
        swr(3'h0, 8'hFF); rd(3'h0, v); chk("reset_control_status locked", 8'h1C, v);
        unl = 1'b1;
        swr(3'h0, 8'hFF); rd(3'h0, v); chk("reset_control_status bit5", 8'hDF, v);
        chk("prio on", 1'b1, ipe);
        swr(3'h0, 8'h00); rd(3'h0, v); chk("lwe sticky", 8'h5C, v);
        chk("prio off", 1'b0, ipe);
        ev(1); rd(3'h0, v); chk("master_clear_pin", 8'h1C, v);
        ev(5); rd(3'h0, v); chk("sleep", 8'h18, v);
        ev(6); rd(3'h0, v); chk("wdt timeout", 8'h10, v);
        ev(4); rd(3'h0, v); chk("wdt clear", 8'h1C, v);
        swr(3'h0, 8'h13); ev(3); rd(3'h0, v); chk("reset instr", 8'h0F, v);
        ev(2); rd(3'h0, v); chk("brownout", 8'h0E, v);
        ev(0); rd(3'h0, v); chk("power on", 8'h1C, v);
        rd(3'h1, v); chk("memc reset", 8'h00, v);
        swr(3'h1, 8'hFF); rd(3'h1, v); chk("memc mask", 8'hF3, v);
        chk("bus pins", 1'b1, bpd);
        chk("ram map", 1'b1, rip);
        swr(3'h1, 8'h00); stp(); chk("bus pins off", 1'b0, bpd);
        $display("test regs done");
    endtask
    localparam logic [21:0] P0 [4] = '{22'h012345, 22'h3FFFFF, 22'h200000, 22'h1FFFFF};
    localparam logic [21:0] PA [4] = '{22'h012345, 22'h3FFFFF, 22'h200000, 22'h000000};
    localparam logic [21:0] PN [4] = '{22'h012345, 22'h200000, 22'h3FFFFF, 22'h000000};
    task automatic t_ptr();
        tau_upd_t ua [4];
        int n;
        logic [5:0] f;
        logic [7:0] u, h, l;
        ua = '{TAU_UPD_NONE, TAU_UPD_POSTINC, TAU_UPD_POSTDEC, TAU_UPD_PREINC};
        for (int i = 0; i < 4; i++)
        begin
            setp(P0[i]);
            op(1'b0, ua[i], 1'b0, n, f);
            chk("read cycles", 22'(8), 22'(n));
            chk("access addr", PA[i], pm_addr);
            rd(3'h2, l); chk("latch", pmb(PA[i]), l);
            rd(3'h3, u);
            rd(3'h4, h);
            rd(3'h5, l);
            chk("next ptr", PN[i], {u[5:0], h, l});
        end
        $display("test pointer done");
    endtask
    task automatic t_int();
        int n;
        logic [5:0] f;
        swr(3'h0, 8'h40);
        vpp = 1'b1;
        setp(22'h000100);
        swr(3'h2, 8'h3C); op(1'b1, TAU_UPD_POSTINC, 1'b0, n, f);
        chk("even write", 6'h20, f);
        swr(3'h2, 8'hC3); op(1'b1, TAU_UPD_NONE, 1'b0, n, f);
        chk("odd write", 6'h10, f);
        chk("word data", 16'hC33C, wdata);
        // the pin passes a two-flop synchroniser: let it settle before the write
        vpp = 1'b0;
        stp();
        stp();
        op(1'b1, TAU_UPD_NONE, 1'b0, n, f);
        chk("no vpp", 1'b0, f[4]);
        ev(1);
        vpp = 1'b1;
        stp();
        stp();
        op(1'b1, TAU_UPD_NONE, 1'b0, n, f);
        chk("no lwe", 1'b0, f[4]);
        $display("test internal done");
    endtask
    localparam logic [1:0] WM [7] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
    localparam logic [7:0] WL [7] = '{8'hA1, 8'hB2, 8'h77, 8'h5E, 8'h5E, 8'h6D, 8'h6D};
    localparam logic [5:0] WF [7] = '{6'h00, 6'h08, 6'h00, 6'h0A, 6'h09, 6'h08, 6'h04};
    localparam logic [15:0] WD [7] = '{16'h0, 16'hB2A1, 16'h0, 16'h5E5E, 16'h5E5E,
        16'h6D6D, 16'h6D6D};
    task automatic t_ext();
        int n;
        logic [5:0] f;
        logic [7:0] v;
        for (int w = 0; w < 4; w++)
        begin
            swr(3'h1, {2'h0, 2'(w), 4'h0});
            setp(22'h000010);
            op(1'b0, TAU_UPD_NONE, 1'b1, n, f);
            chk("wait cycles", 22'(8 + 4 * (3 - w)), 22'(n));
            rd(3'h2, v); chk("ext latch", pmb(22'h000010), v);
        end
        for (int i = 0; i < 7; i++)
        begin
            swr(3'h1, {4'h3, 2'h0, WM[i]});
            setp(i == 0 || i == 4 || i == 6 ? 22'h000020 : 22'h000021);
            swr(3'h2, WL[i]);
            op(1'b1, TAU_UPD_NONE, 1'b1, n, f);
            chk("ext strobes", WF[i], f);
            if (WF[i] != 6'h00)
                chk("ext data", WD[i], bus.data);
        end
        swr(3'h1, 8'h70); op(1'b0, TAU_UPD_NONE, 1'b1, n, f);
        rd(3'h2, v); chk("ram mapped", 8'h00, v);
        $display("test external done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_regs();
        t_ptr();
        t_int();
        t_ext();
        give_verdict();
    end
endmodule
`default_nettype wire
